//--- cit_consts.svh
// Register map, field positions and reset values of the capture/interval timer.
// Assumes an 8-bit register port with byte addresses.
`ifndef CIT_CONSTS_SVH
`define CIT_CONSTS_SVH

`define CIT_ADDR_MODE 8'hbc
`define CIT_ADDR_FCAP 8'hbd
`define CIT_ADDR_RCAP 8'hbe
`define CIT_ADDR_MSTOP 8'hfa
`define CIT_ADDR_PCTL 8'hc0
`define CIT_ADDR_IRQ 8'hc1

`define CIT_MODE_RST 8'h00
`define CIT_MSTOP_RST 8'hff
`define CIT_MSTOP_BIT 3
`define CIT_PCTL_CMODE 0
`define CIT_PCTL_FEN 1
`define CIT_IRQ_FLAG 0
`define CIT_IRQ_EN 1
`define CIT_MODE_OVERFLOW_HIGH_FLAG 7
`define CIT_MODE_OVERFLOW_LOW_FLAG 6

`define CIT_FILT_STAGES 5
`define CIT_PRE_W 6

`endif

//--- cit_pkg.sv
// Types of the capture/interval timer: clock sources, power modes, state.
// Assumes cit_consts.svh for widths.
`include "cit_consts.svh"

package cit_pkg;

  typedef enum logic [1:0] {
    CIT_DIV64 = 2'b00,
    CIT_DIV32 = 2'b01,
    CIT_DIV2 = 2'b10,
    CIT_WDIV4 = 2'b11
  } cit_cks_e;

  typedef enum logic [2:0] {
    CIT_ACTIVE = 3'b000,
    CIT_SLEEP = 3'b001,
    CIT_WATCH = 3'b010,
    CIT_SUBACT = 3'b011,
    CIT_SUBSLP = 3'b100,
    CIT_STANDBY = 3'b101
  } cit_pwr_e;

  typedef enum logic [1:0] {
    CIT_SUB_W8 = 2'b00,
    CIT_SUB_W4 = 2'b01,
    CIT_SUB_W2 = 2'b10
  } cit_sub_e;

  typedef struct packed {
    logic [`CIT_PRE_W-1:0] pre;
    logic [1:0] wpre;
    logic wsync1;
    logic wsync2;
    logic wprev;
    logic lvl_prev;
    logic pin_q;
    logic [`CIT_FILT_STAGES-1:0] fsh;
    logic fout;
    logic finit;
    logic cap_prev;
    logic [7:0] cnt;
    logic [7:0] fcap;
    logic [7:0] rcap;
    logic overflow_high_flag;
    logic overflow_low_flag;
    logic overflow_high_flag_arm;
    logic overflow_low_flag_arm;
    logic overflow_irq_enable;
    logic irq_edge_select;
    logic [1:0] ccl;
    cit_cks_e cks;
    logic [7:0] mreg;
    logic cmode;
    logic fen;
    logic iflag;
    logic ien;
    logic [7:0] rdata;
  } cit_state_s;

endpackage : cit_pkg

//--- cit_timer.sv
// Capture/interval timer with noise filter and register port.
// Assumes all inputs synchronous to sys_clk_i; watch clock is a sampled level.
`timescale 1ns/100ps
`include "cit_consts.svh"

module cit_timer
  import cit_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Pins and system state
  input wire logic cap_pin_i,
  input wire logic watch_clk_i,
  input wire logic [2:0] pwr_mode_i,
  input wire logic [1:0] sub_clk_sel_i,
  // Interrupt request
  output logic irq_o
);

  cit_state_s s_q;
  cit_state_s s_d;

  logic lvl;
  logic clk_rise;
  logic clk_fall;
  logic mode_ok;
  logic run;
  logic samp;
  logic in_sig;
  logic cap_sig;
  logic rise_edge;
  logic fall_edge;
  logic inc;
  logic ovf;
  logic clr;
  logic [`CIT_FILT_STAGES-1:0] fsh_n;

  always_comb begin
    case (s_q.cks)
      CIT_DIV64: lvl = s_q.pre[5];
      CIT_DIV32: lvl = s_q.pre[4];
      CIT_DIV2: lvl = s_q.pre[0];
      CIT_WDIV4: lvl = s_q.wpre[1];
      default: lvl = 1'b0;
    endcase
  end

  assign clk_rise = lvl & ~s_q.lvl_prev;
  assign clk_fall = ~lvl & s_q.lvl_prev;

  // Power mode gating of counter and filter
  always_comb begin
    case (cit_pwr_e'(pwr_mode_i))
      CIT_ACTIVE: mode_ok = 1'b1;
      CIT_SLEEP: mode_ok = 1'b1;
      CIT_WATCH: mode_ok = (s_q.cks == CIT_WDIV4);
      // Sub modes need watch/4 and subclock /2
      CIT_SUBACT: mode_ok = (s_q.cks == CIT_WDIV4) && (sub_clk_sel_i == CIT_SUB_W2);
      CIT_SUBSLP: mode_ok = (s_q.cks == CIT_WDIV4) && (sub_clk_sel_i == CIT_SUB_W2);
      default: mode_ok = 1'b0;
    endcase
  end

  assign run = s_q.mreg[`CIT_MSTOP_BIT] & mode_ok;
  assign samp = run & (s_q.fen ? clk_rise : 1'b1);
  assign fsh_n = {s_q.fsh[`CIT_FILT_STAGES-2:0], s_q.pin_q};
  // Any change of the chosen input counts as an edge while running in capture mode
  assign in_sig = s_q.fen ? s_q.fout : s_q.pin_q;
  // Capture input reads low in interval mode
  assign cap_sig = s_q.cmode & in_sig;
  assign rise_edge = run & cap_sig & ~s_q.cap_prev;
  assign fall_edge = run & ~cap_sig & s_q.cap_prev;
  assign inc = run & clk_fall;
  assign ovf = inc & (s_q.cnt == 8'hff);
  assign clr = s_q.cmode & ((rise_edge & s_q.ccl[1]) | (fall_edge & s_q.ccl[0]));

  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.pre = s_q.pre + 6'h01;
    // Two-flop synchroniser for the watch clock
    s_d.wsync1 = watch_clk_i;
    s_d.wsync2 = s_q.wsync1;
    s_d.wprev = s_q.wsync2;
    if (s_q.wsync2 && !s_q.wprev) begin
      s_d.wpre = s_q.wpre + 2'h1;
    end
    s_d.lvl_prev = lvl;
    s_d.pin_q = cap_pin_i;
    s_d.cap_prev = cap_sig;

    // Shift on sample, follow only on full match
    if (samp) begin
      s_d.fsh = fsh_n;
    end
    if (run) begin
      // Output valid after five low samples
      if (s_q.fsh == 5'h00) begin
        s_d.fout = 1'b0;
        s_d.finit = 1'b1;
      end else if (s_q.fsh == 5'h1f && s_q.finit) begin
        s_d.fout = 1'b1;
      end
    end

    if (rise_edge) begin
      s_d.rcap = s_q.cnt;
    end
    if (fall_edge) begin
      s_d.fcap = s_q.cnt;
    end
    if (clr) begin
      s_d.cnt = 8'h00;
    end else if (inc) begin
      s_d.cnt = s_q.cnt + 8'h01;
    end

    // Register reads
    if (reg_rd_i) begin
      case (reg_addr_i)
        `CIT_ADDR_MODE: begin
          s_d.rdata = {s_q.overflow_high_flag, s_q.overflow_low_flag, s_q.overflow_irq_enable, s_q.irq_edge_select, s_q.ccl, s_q.cks};
          s_d.overflow_high_flag_arm = s_q.overflow_high_flag_arm | s_q.overflow_high_flag;
          s_d.overflow_low_flag_arm = s_q.overflow_low_flag_arm | s_q.overflow_low_flag;
        end
        `CIT_ADDR_FCAP: s_d.rdata = s_q.fcap;
        `CIT_ADDR_RCAP: s_d.rdata = s_q.rcap;
        `CIT_ADDR_MSTOP: s_d.rdata = s_q.mreg;
        `CIT_ADDR_PCTL: s_d.rdata = {6'h00, s_q.fen, s_q.cmode};
        `CIT_ADDR_IRQ: s_d.rdata = {6'h00, s_q.ien, s_q.iflag};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `CIT_ADDR_MODE: begin
          // Mode register held in module standby
          if (s_q.mreg[`CIT_MSTOP_BIT]) begin
            {s_d.overflow_irq_enable, s_d.irq_edge_select, s_d.ccl} = reg_wdata_i[5:2];
            s_d.cks = cit_cks_e'(reg_wdata_i[1:0]);
            if (!reg_wdata_i[`CIT_MODE_OVERFLOW_HIGH_FLAG] && s_q.overflow_high_flag_arm) begin
              s_d.overflow_high_flag = 1'b0;
              s_d.overflow_high_flag_arm = 1'b0;
            end
            if (!reg_wdata_i[`CIT_MODE_OVERFLOW_LOW_FLAG] && s_q.overflow_low_flag_arm) begin
              s_d.overflow_low_flag = 1'b0;
              s_d.overflow_low_flag_arm = 1'b0;
            end
          end
        end
        `CIT_ADDR_MSTOP: s_d.mreg = reg_wdata_i;
        `CIT_ADDR_PCTL: begin
          s_d.cmode = reg_wdata_i[`CIT_PCTL_CMODE];
          s_d.fen = reg_wdata_i[`CIT_PCTL_FEN];
        end
        `CIT_ADDR_IRQ: begin
          s_d.ien = reg_wdata_i[`CIT_IRQ_EN];
          if (!reg_wdata_i[`CIT_IRQ_FLAG]) begin
            s_d.iflag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Overflow flag by input level; set wins over clear
    if (ovf) begin
      if (cap_sig) begin
        s_d.overflow_high_flag = 1'b1;
      end else begin
        s_d.overflow_low_flag = 1'b1;
      end
    end
    // Selected edge sets the interrupt flag
    if ((rise_edge && !s_q.irq_edge_select) || (fall_edge && s_q.irq_edge_select)) begin
      s_d.iflag = 1'b1;
    end
    if (ovf && s_q.overflow_irq_enable) begin
      s_d.iflag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    // Reset state: registers zero, /64 source, not stopped
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.mreg <= `CIT_MSTOP_RST;
      // Stages start high so five low samples are needed
      s_q.fsh <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign irq_o = s_q.iflag & s_q.ien;

  // Checks

  a_div64_tick: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (inc && s_q.cks == CIT_DIV64 && $stable(s_q.cks)) |-> s_q.pre == 6'h00)
    else $error("Divide-by-64 tick off its phase");

  a_stop_freezes: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !s_q.mreg[`CIT_MSTOP_BIT] |=> ($stable(s_q.cnt) && $stable(s_q.rcap) && $stable(s_q.fcap)))
    else $error("Timer moved in module standby");

  a_filter_match: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(s_q.fout) |-> ($past(s_q.fsh) == 5'h1f || $past(s_q.fsh) == 5'h00))
    else $error("Filter output changed without full match");

  a_filter_init: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(s_q.finit) |-> $past(s_q.fsh) == 5'h00)
    else $error("Filter initialised without five low samples");

  a_rise_capture: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rise_edge |=> s_q.rcap == $past(s_q.cnt))
    else $error("Rising capture missed count");

  a_edge_clear: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (fall_edge && s_q.cmode && s_q.ccl[0]) |=> s_q.cnt == 8'h00)
    else $error("Falling edge did not clear counter");

  a_ovf_high: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (ovf && cap_sig) |=> (s_q.overflow_high_flag && s_q.cnt == 8'h00))
    else $error("High overflow flag not set");

  a_interval_wrap: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (ovf && !s_q.cmode) |=> s_q.overflow_low_flag)
    else $error("Interval wrap did not set low flag");

  a_edge_irq: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (fall_edge && s_q.irq_edge_select && s_q.ien) |=> irq_o)
    else $error("Selected edge raised no request");

  a_ovf_irq: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (ovf && s_q.overflow_irq_enable) |=> s_q.iflag)
    else $error("Overflow interrupt flag not set");

  a_watch_gate: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (pwr_mode_i == CIT_WATCH && s_q.cks != CIT_WDIV4) |-> (!inc && !rise_edge && !fall_edge))
    else $error("Timer ran in watch mode on wrong source");

  a_fall_capture: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    fall_edge |=> s_q.fcap == $past(s_q.cnt))
    else $error("Falling capture missed count");

  a_rise_clear: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (rise_edge && s_q.cmode && s_q.ccl[1]) |=> s_q.cnt == 8'h00)
    else $error("Rising edge did not clear counter");

  a_ovf_low: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (ovf && !cap_sig) |=> (s_q.overflow_low_flag && s_q.cnt == 8'h00))
    else $error("Low overflow flag not set");

  a_rise_irq: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (rise_edge && !s_q.irq_edge_select) |=> s_q.iflag)
    else $error("Rising edge did not set interrupt flag");

  a_reset_state: assert property (
    @(posedge sys_clk_i)
    $fell(sys_rst_i) |-> (s_q.cnt == 8'h00 && s_q.rcap == 8'h00 && s_q.fcap == 8'h00 &&
      {s_q.overflow_high_flag, s_q.overflow_low_flag, s_q.overflow_irq_enable, s_q.irq_edge_select, s_q.ccl} == 6'h00 && s_q.cks == CIT_DIV64 &&
      s_q.mreg == `CIT_MSTOP_RST && reg_rdata_o == 8'h00 && !irq_o))
    else $error("Reset state not cleared");

  a_stop_mode_hold: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !s_q.mreg[`CIT_MSTOP_BIT] |=> ($stable(s_q.cks) && $stable(s_q.ccl) &&
      $stable(s_q.overflow_irq_enable) && $stable(s_q.irq_edge_select)))
    else $error("Mode register changed in module standby");

  a_standby_halt: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (pwr_mode_i == CIT_STANDBY) |-> (!inc && !rise_edge && !fall_edge))
    else $error("Timer ran in standby");

  a_sub_gate: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ((pwr_mode_i == CIT_SUBACT || pwr_mode_i == CIT_SUBSLP) &&
      (s_q.cks != CIT_WDIV4 || sub_clk_sel_i != CIT_SUB_W2)) |-> (!inc && !rise_edge && !fall_edge))
    else $error("Timer ran in sub mode on wrong clocks");

  a_filter_hold: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.fsh != 5'h00 && s_q.fsh != 5'h1f) |=> $stable(s_q.fout))
    else $error("Filter output moved on mixed stages");

  a_count_step: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (inc && !clr) |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
    else $error("Counter did not step by one");

  a_count_hold: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (!inc && !clr) |=> $stable(s_q.cnt))
    else $error("Counter moved without tick or clear");

  a_div32_tick: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (inc && s_q.cks == CIT_DIV32 && $stable(s_q.cks)) |-> s_q.pre[4:0] == 5'h00)
    else $error("Divide-by-32 tick off its phase");

  a_div2_tick: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (inc && s_q.cks == CIT_DIV2 && $stable(s_q.cks)) |-> !s_q.pre[0])
    else $error("Divide-by-2 tick off its phase");

  a_filter_bypass: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (run && !s_q.fen) |=> s_q.fsh == $past(fsh_n))
    else $error("Filter did not sample on system clock");

endmodule : cit_timer

//--- cit_pulse_src.sv
// External pulse source driving the capture pin.
// Assumes the bench calls pulse() from its clocked sequence.
`timescale 1ns/100ps

module cit_pulse_src (
  // Clock
  input wire logic sys_clk_i,
  // Capture pin
  output logic cap_pin_o
);
  initial cap_pin_o = 1'b0;

  task automatic pulse(input int w);
    int n;
    n = (w < 2) ? 2 : w;
    @(posedge sys_clk_i);
    cap_pin_o <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    cap_pin_o <= 1'b0;
  endtask : pulse

  task automatic glitch(input int w);
    @(posedge sys_clk_i);
    cap_pin_o <= 1'b1;
    repeat (w) @(posedge sys_clk_i);
    cap_pin_o <= 1'b0;
  endtask : glitch
endmodule : cit_pulse_src

//--- capture_interval_timer_filter_tb.sv
// Self-checking bench of the capture/interval timer.
// Assumes cit_timer and cit_pulse_src compiled before it.
`timescale 1ns/100ps
`include "cit_consts.svh"

module capture_interval_timer_filter_tb;
  import cit_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic pin;
  logic [3:0] wcnt = 4'h0;
  logic [2:0] pwr = 3'h0;
  logic [1:0] sub = 2'h2;
  logic irq;
  logic [7:0] v;
  int err_total = 0;
  int n_compared = 0;

  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) wcnt <= wcnt + 4'h1;

  cit_timer i_cit_timer (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .cap_pin_i(pin), .watch_clk_i(wcnt[3]),
    .pwr_mode_i(pwr), .sub_clk_sel_i(sub), .irq_o(irq)
  );

  cit_pulse_src i_cit_pulse_src (.sys_clk_i(sys_clk_i), .cap_pin_o(pin));

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %0t seen %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : wrr

  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rdr

  task automatic t_reset;
    logic [7:0] a [7] = '{8'hbc, 8'hbd, 8'hbe, 8'hfa, 8'hc0, 8'hc1, 8'h55};
    logic [7:0] e [7] = '{`CIT_MODE_RST, 8'h00, 8'h00, `CIT_MSTOP_RST, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      rdr(a[i]);
      chk(v, e[i]);
    end
    chk({7'h00, irq}, 8'h00);
    rdr(`CIT_ADDR_MSTOP);
    @(posedge sys_clk_i);
    #1 chk(rdata, 8'h00);
  endtask : t_reset

  // Both-edge clear on /2, rising edge flags
  task automatic t_capture;
    wrr(8'hbc, 8'h0e);
    wrr(8'hc0, 8'h01);
    wrr(8'hc1, 8'h02);
    i_cit_pulse_src.pulse(40);
    repeat (4) @(posedge sys_clk_i);
    chk({7'h00, irq}, 8'h01);
    rdr(8'hbd);
    chk({7'h00, (v >= 8'd19) && (v <= 8'd21)}, 8'h01);
    wrr(8'hc1, 8'h02);
    i_cit_pulse_src.pulse(30);
    repeat (4) @(posedge sys_clk_i);
    rdr(8'hbd);
    chk({7'h00, (v >= 8'd14) && (v <= 8'd16)}, 8'h01);
  endtask : t_capture

  task automatic t_filter;
    wrr(8'hc0, 8'h00);
    wrr(8'hc0, 8'h02);
    repeat (20) @(posedge sys_clk_i);
    wrr(8'hc0, 8'h03);
    repeat (20) @(posedge sys_clk_i);
    wrr(8'hc1, 8'h02);
    i_cit_pulse_src.glitch(6);
    repeat (30) @(posedge sys_clk_i);
    rdr(8'hc1);
    chk(v, 8'h02);
    i_cit_pulse_src.pulse(20);
    repeat (30) @(posedge sys_clk_i);
    rdr(8'hc1);
    chk(v, 8'h03);
  endtask : t_filter

  task automatic t_overflow;
    wrr(8'hc0, 8'h00);
    wrr(8'hbc, 8'h22);
    wrr(8'hc1, 8'h02);
    repeat (600) @(posedge sys_clk_i);
    rdr(8'hbc);
    chk(v, 8'h62);
    rdr(8'hc1);
    chk(v, 8'h03);
    wrr(8'hbc, 8'h22);
    rdr(8'hbc);
    chk(v, 8'h22);
  endtask : t_overflow

  task automatic t_stop;
    wrr(8'hc1, 8'h00);
    wrr(8'hfa, 8'hf7);
    rdr(8'hfa);
    chk(v, 8'hf7);
    wrr(8'hbc, 8'h05);
    rdr(8'hbc);
    chk(v, 8'h22);
    wrr(8'hfa, 8'hff);
  endtask : t_stop

  task automatic t_watch;
    wrr(8'hc0, 8'h01);
    wrr(8'hc1, 8'h02);
    @(posedge sys_clk_i);
    pwr <= 3'h2;
    i_cit_pulse_src.pulse(40);
    repeat (4) @(posedge sys_clk_i);
    rdr(8'hc1);
    chk(v, 8'h02);
    @(posedge sys_clk_i);
    pwr <= 3'h5;
    i_cit_pulse_src.pulse(40);
    repeat (4) @(posedge sys_clk_i);
    rdr(8'hc1);
    chk(v, 8'h02);
    @(posedge sys_clk_i);
    pwr <= 3'h0;
    // Watch/4 source keeps running, falling edge flags
    wrr(8'hbc, 8'h13);
    wrr(8'hc1, 8'h02);
    @(posedge sys_clk_i);
    pwr <= 3'h2;
    i_cit_pulse_src.pulse(40);
    repeat (4) @(posedge sys_clk_i);
    rdr(8'hc1);
    chk(v, 8'h03);
    @(posedge sys_clk_i);
    pwr <= 3'h0;
  endtask : t_watch

  // Input held high across a wrap
  task automatic t_ovf_high;
    wrr(8'hbc, 8'h02);
    i_cit_pulse_src.pulse(520);
    repeat (4) @(posedge sys_clk_i);
    rdr(8'hbc);
    chk({7'h00, v[7]}, 8'h01);
  endtask : t_ovf_high

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_capture();
    t_filter();
    t_overflow();
    t_stop();
    t_watch();
    t_ovf_high();
    test_done();
  end

  initial begin
    #500000;
    err_total++;
    test_done();
  end
endmodule : capture_interval_timer_filter_tb
